//--- rtl/rloip_port.sv
/*
Register port of a 32-channel relay output card with two isolated inputs and a board identifier.
Assumes the bridge presents one-cycle read and write strobes with a 16-bit word and synchronous inputs.
*/
// Notes on behaviour
// (R01) All registers are sixteen bits, bit 0 least significant.
// (R02) Host uses only 16-bit I/O accesses to reach the registers.
// (R03) Offset zero writes and reads relay channels 1 to 16.
// (R04) Offset two writes and reads relay channels 17 to 32.
// (R05) Offset four reads the two input levels; writes there do nothing.
// (R06) Each control bit drives one relay; bit equals channel minus group start.
// (R07) Writing one closes a relay, writing zero opens it.
// (R08) State bits read one when closed, zero when open, same mapping.
// (R09) State reads cover all thirty-two channels, sixteen per offset.
// (R10) Four switches give board id 0 to 15; on switch gives zero bit.
// (R11) One indicator output per relay, lit while energised, mirrored on headers.
// (R12) Input register bit 0 is channel 0, bit 1 channel 1, high reads one.
// (R13) A write to offset eight clears the pending input interrupt request unless an input rises in the same cycle.
// (R14) Interrupt request raised only on a rising edge of either input; the code also raises one if an input is already high when reset ends.
// (R15) Reset opens all relays and clears any pending interrupt request.
// (R16) Unassigned bits read zero and ignore writes.
`timescale 1ns/1ps
module rloip_port
	import rloip_pkg::*;
#(
	parameter int RELAYS = 32
)
(
	input wire logic mclk,
	input wire logic srst,
	input wire logic [RLOIP_ADDR_W-1:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [RLOIP_DATA_W-1:0] bus_wdata,
	output logic [RLOIP_DATA_W-1:0] bus_rdata,
	input wire logic [RLOIP_INPUTS-1:0] input_level,
	input wire logic [RLOIP_ID_W-1:0] board_id_switch,
	output logic [RLOIP_ID_W-1:0] board_id,
	output logic [RELAYS-1:0] relay_control_bit,
	output logic [RELAYS/2-1:0] indicator_header_a,
	output logic [RELAYS/2-1:0] indicator_header_b,
	output logic irq_request
);
	// --------------------------------
	// Parameter check
	// --------------------------------

	if (RELAYS != 2 * RLOIP_DATA_W)
	begin : g_bad_relays
		$error("RELAYS must equal two register widths.");
	end

	// --------------------------------
	// Local constants
	// --------------------------------

	localparam int GROUP_W = RLOIP_DATA_W;
	localparam int GROUPS = RELAYS / GROUP_W;
	localparam int HALF = RELAYS / 2;
	localparam int PAD_W = RLOIP_DATA_W - RLOIP_INPUTS;

	// --------------------------------
	// Register state
	// --------------------------------

	logic [RELAYS-1:0] relay;
	logic [RELAYS-1:0] next_relay;
	logic [RLOIP_INPUTS-1:0] input_prev;
	logic [RLOIP_INPUTS-1:0] next_input_prev;
	logic irq_pend;
	logic next_irq_pend;
	logic [RLOIP_DATA_W-1:0] next_rdata;
	logic [RLOIP_ID_W-1:0] next_board_id;

	// --------------------------------
	// Decode signals
	// --------------------------------

	logic wr_relay_low;
	logic wr_relay_high;
	logic wr_irq_clear;
	logic [RELAYS-1:0] chan_wr;
	logic [RLOIP_INPUTS-1:0] input_rise;
	logic any_rise;

	// --------------------------------
	// Output next values
	// --------------------------------

	logic [RELAYS-1:0] next_relay_out;
	logic [HALF-1:0] next_header_a;
	logic [HALF-1:0] next_header_b;
	logic next_irq_out;

	// --------------------------------
	// Address decode functions
	// --------------------------------

	// Compares an access offset against one register offset.
	function automatic logic hit(input logic [RLOIP_ADDR_W-1:0] a, input logic [RLOIP_ADDR_W-1:0] ofs);
		hit = (a == ofs);
	endfunction

	// Qualifies an offset match with the write strobe.
	function automatic logic wr_hit(
		input logic wr,
		input logic [RLOIP_ADDR_W-1:0] a,
		input logic [RLOIP_ADDR_W-1:0] ofs
	);
		wr_hit = wr && hit(a, ofs);
	endfunction

	// --------------------------------
	// Write decode
	// --------------------------------

	always_comb
	begin
		wr_relay_low = wr_hit(bus_wr, bus_addr, RLOIP_OFS_RELAY_LOW); // [R03]
		wr_relay_high = wr_hit(bus_wr, bus_addr, RLOIP_OFS_RELAY_HIGH); // [R04]
		wr_irq_clear = wr_hit(bus_wr, bus_addr, RLOIP_OFS_IRQ_CLEAR); // [R13]
	end

	// --------------------------------
	// Channel write enables
	// --------------------------------

	for (genvar k = 0; k < RELAYS; k++)
	begin : g_chan
		if (k < GROUP_W)
		begin : g_low
			assign chan_wr[k] = wr_relay_low; // [R06]
		end
		else
		begin : g_high
			assign chan_wr[k] = wr_relay_high; // [R06]
		end
	end

	// --------------------------------
	// Relay state
	// --------------------------------

	always_comb
	begin
		next_relay = relay;
		for (int k = 0; k < RELAYS; k++)
		begin
			if (chan_wr[k])
				next_relay[k] = bus_wdata[k % GROUP_W]; // [R06] [R07]
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			relay <= {GROUPS{RLOIP_RELAY_RESET}}; // [R15]
		else
			relay <= next_relay;
	end

	// --------------------------------
	// Input edges and interrupt
	// --------------------------------

	always_comb
	begin
		next_input_prev = input_level;
		input_rise = input_level & ~input_prev; // [R14]
		any_rise = |input_rise;
		next_irq_pend = irq_pend;
		if (wr_irq_clear)
			next_irq_pend = 1'b0; // [R13]
		if (any_rise)
			next_irq_pend = 1'b1; // [R14]
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			input_prev <= {RLOIP_INPUTS{1'b0}};
			irq_pend <= 1'b0; // [R15]
		end
		else
		begin
			input_prev <= next_input_prev;
			irq_pend <= next_irq_pend;
		end
	end

	// --------------------------------
	// Read data
	// --------------------------------

	always_comb
	begin
		next_rdata = RLOIP_READ_ZERO; // [R16]
		if (bus_rd)
		begin
			case (bus_addr)
				RLOIP_OFS_RELAY_LOW: next_rdata = relay[GROUP_W-1:0]; // [R08] [R09] [R01]
				RLOIP_OFS_RELAY_HIGH: next_rdata = relay[RELAYS-1:GROUP_W]; // [R08] [R09]
				RLOIP_OFS_INPUT: next_rdata = {{PAD_W{1'b0}}, input_level}; // [R05] [R12]
				default: next_rdata = RLOIP_READ_ZERO; // [R16]
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			bus_rdata <= RLOIP_READ_ZERO;
		else
			bus_rdata <= next_rdata;
	end

	// --------------------------------
	// Board identifier
	// --------------------------------

	always_comb
	begin
		next_board_id = ~board_id_switch; // [R10]
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			board_id <= {RLOIP_ID_W{1'b0}};
		else
			board_id <= next_board_id;
	end

	// --------------------------------
	// Output registers
	// --------------------------------

	always_comb
	begin
		next_relay_out = next_relay;
		next_header_a = next_relay[HALF-1:0]; // [R11]
		next_header_b = next_relay[RELAYS-1:HALF]; // [R11]
		next_irq_out = next_irq_pend;
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			relay_control_bit <= {RELAYS{1'b0}}; // [R15]
			indicator_header_a <= {HALF{1'b0}};
			indicator_header_b <= {HALF{1'b0}};
			irq_request <= 1'b0; // [R15]
		end
		else
		begin
			relay_control_bit <= next_relay_out;
			indicator_header_a <= next_header_a;
			indicator_header_b <= next_header_b;
			irq_request <= next_irq_out;
		end
	end

endmodule

//--- rtl/rloip_pkg.sv
/*
Package for the relay output and isolated input port: register offsets, widths, reset values.
Assumes a 16-bit local I/O bus behind a host bridge, offsets relative to the block base.
*/
package rloip_pkg;
	localparam int RLOIP_DATA_W = 16;
	localparam int RLOIP_ADDR_W = 8;
	localparam int RLOIP_INPUTS = 2;
	localparam int RLOIP_ID_W = 4;
	localparam logic [RLOIP_ADDR_W-1:0] RLOIP_OFS_RELAY_LOW = 8'h00;
	localparam logic [RLOIP_ADDR_W-1:0] RLOIP_OFS_RELAY_HIGH = 8'h02;
	localparam logic [RLOIP_ADDR_W-1:0] RLOIP_OFS_INPUT = 8'h04;
	localparam logic [RLOIP_ADDR_W-1:0] RLOIP_OFS_IRQ_CLEAR = 8'h08;
	localparam logic [RLOIP_DATA_W-1:0] RLOIP_RELAY_RESET = 16'h0000;
	localparam logic [RLOIP_DATA_W-1:0] RLOIP_READ_ZERO = 16'h0000;
endpackage

//--- tb/rloip_props.sv
/* Checker on rloip_port ports. Bound to every rloip_port below. */
`timescale 1ns/1ps
module rloip_props #(parameter int RELAYS=32) (input wire logic mclk, srst, bus_wr, bus_rd, irq_request,
input wire logic [7:0] bus_addr, input wire logic [15:0] bus_wdata, bus_rdata,
input wire logic [1:0] input_level, input wire logic [RELAYS-1:0] relay_control_bit);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	sequence s_rise; |(input_level&~$past(input_level)); endsequence
	sequence s_clr; bus_wr&&bus_addr==8'h8&&!$past(srst)&&!(|(input_level&~$past(input_level))); endsequence
	a_lo_wr: assert property(bus_wr&&bus_addr==8'h0|=>relay_control_bit[15:0]==$past(bus_wdata))else $error("bad");
	a_hi_wr: assert property(bus_wr&&bus_addr==8'h2|=>relay_control_bit[31:16]==$past(bus_wdata))else $error("bad");
	a_lo_rd: assert property(bus_rd&&bus_addr==8'h0|=>bus_rdata==relay_control_bit[15:0])else $error("bad");
	a_in_rd: assert property(bus_rd&&bus_addr==8'h4|=>bus_rdata=={14'h0,$past(input_level)})else $error("bad");
	a_rd_idle: assert property(!bus_rd|=>bus_rdata==16'h0)else $error("bad");
	a_irq_set: assert property(s_rise|=>irq_request)else $error("bad");
	a_irq_clr: assert property(s_clr|=>!irq_request)else $error("bad");
	a_irq_only: assert property(!irq_request&&!$past(srst)&&!(|(input_level&~$past(input_level)))|=>!irq_request)
		else $error("bad");
	a_hi_rd: assert property(bus_rd&&bus_addr==8'h2|=>bus_rdata==relay_control_bit[31:16])else $error("bad");
endmodule
bind rloip_port rloip_props #(.RELAYS(RELAYS)) rloip_props_i(.*);

//--- tb/rloip_host.sv
/* Host bus model. Drives at falling mclk, one access per call. */
`timescale 1ns/1ps
module rloip_host (input wire logic mclk, input wire logic [15:0] bus_rdata, output logic bus_wr, bus_rd,
output logic [7:0] bus_addr, output logic [15:0] bus_wdata);
	initial {bus_addr,bus_wr,bus_rd,bus_wdata}='0;
	// One 16-bit word per strobe.
	task xfer(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
		@(negedge mclk) {bus_addr,bus_wr,bus_rd,bus_wdata}={a,w,!w,d};
		@(negedge mclk) {bus_wr,bus_rd,bus_wdata}={2'h0,~d};
		q=bus_rdata;
	endtask
endmodule

//--- tb/rloip_port_tb_top.sv
/* Bench for rloip_port. rloip_host drives the register bus. */
`timescale 1ns/1ps
module rloip_port_tb_top;
	logic mclk=0,srst=1,bus_wr,bus_rd,irq_request;
	logic [1:0] input_level=2'h0;
	logic [3:0] board_id_switch=4'hA,board_id;
	logic [7:0] bus_addr;
	logic [15:0] bus_wdata,bus_rdata,r,indicator_header_a,indicator_header_b;
	logic [31:0] relay_control_bit;
	int err_count=0,num_checks=0;
	always #5 mclk=~mclk;
	rloip_port rloip_port_i(.*);
	rloip_host rloip_host_i(.*);
	task ck(input logic [31:0] s,e);num_checks++;if(s!==e)begin err_count++;$display("[FAIL] %0t got %h",$time,s);end
	endtask
	task x(input logic w,input logic [7:0] a,input logic [15:0] d);rloip_host_i.xfer(w,a,d,r);endtask
	task final_report;if(err_count==0&&num_checks>0)$display("*** PASS ***");else $display("*** FAIL ***");$finish;endtask
	task t_relay;x(1,8'h0,16'h8001);x(1,8'h2,16'h4002);ck(relay_control_bit,32'h40028001);
	ck({indicator_header_b,indicator_header_a},32'h40028001);x(0,8'h0,16'h0);ck(r,16'h8001);
	x(0,8'h2,16'h0);ck(r,16'h4002);x(1,8'h0,16'h0);ck(relay_control_bit,32'h40020000);endtask
	task t_in;input_level=2'h2;@(negedge mclk)ck(irq_request,1'h1);x(0,8'h4,16'h0);ck(r,16'h2);
	x(1,8'h8,16'h0);ck(irq_request,1'h0);input_level=2'h0;@(negedge mclk)ck(irq_request,1'h0);
	input_level=2'h1;@(negedge mclk)ck(irq_request,1'h1);x(1,8'h8,16'hFFFF);ck(irq_request,1'h0);endtask
	task t_misc;x(1,8'h4,16'hFFFF);x(1,8'h6,16'hFFFF);ck(relay_control_bit,32'h40020000);x(0,8'h6,16'h0);
	ck(r,16'h0);ck(board_id,4'h5);input_level=2'h2;srst=1;@(negedge mclk)ck(relay_control_bit,32'h0);
	ck(irq_request,1'h0);endtask
	initial begin repeat(12)@(negedge mclk);srst=0;t_relay;t_in;t_misc;final_report;end
	initial begin #9000;err_count++;final_report;end
endmodule
